//--- logic/reload_timer_with_capture.sv
// Reload timer with split and comparator capture modes
`timescale 1ns/1ps
`include "timer_defs.svh"

module reload_timer_with_capture (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_osc,
    input wire logic cmp_out,
    output logic irq
);

    // -----------------------------------------------------------
    // Tick generation
    // -----------------------------------------------------------
    logic [3:0] div12_ff;
    logic [3:0] nxt_div12;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    logic [2:0] ext_div_ff;
    logic [2:0] nxt_ext_div;
    logic cmp_smp_ff;
    logic cmp_prev_ff;
    logic tick12;
    logic ext_edge;
    logic ext_tick;
    logic cmp_rise;

    always_comb begin
        tick12 = (div12_ff == `DIV12_LAST);
        nxt_div12 = tick12 ? 4'h0 : div12_ff + 4'h1;
        ext_edge = ext_sync_ff & ~ext_prev_ff;
        ext_tick = ext_edge && (ext_div_ff == `EXT_DIV_LAST);
        nxt_ext_div = ext_edge ? ext_div_ff + 3'h1 : ext_div_ff;
        cmp_rise = cmp_smp_ff & ~cmp_prev_ff;
    end

    // The first sync stage feeds only the second one
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div12_ff <= 4'h0;
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
            ext_div_ff <= 3'h0;
            cmp_smp_ff <= 1'b0;
            cmp_prev_ff <= 1'b0;
        end else begin
            div12_ff <= nxt_div12;
            ext_meta_ff <= ext_osc;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
            ext_div_ff <= nxt_ext_div;
            cmp_smp_ff <= cmp_out;
            cmp_prev_ff <= cmp_smp_ff;
        end
    end

    // -----------------------------------------------------------
    // Counter, reload and register state
    // -----------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [1:0] clksel_ff;
    logic [1:0] nxt_clksel;
    logic irqen_ff;
    logic nxt_irqen;
    logic [7:0] cnt_lo_ff;
    logic [7:0] nxt_cnt_lo;
    logic [7:0] cnt_hi_ff;
    logic [7:0] nxt_cnt_hi;
    logic [7:0] rld_lo_ff;
    logic [7:0] nxt_rld_lo;
    logic [7:0] rld_hi_ff;
    logic [7:0] nxt_rld_hi;
    logic [2:0] status_ff;
    logic [2:0] nxt_status;
    logic [2:0] mask_ff;
    logic [2:0] nxt_mask;
    logic [15:0] cnt16;
    logic [15:0] rld16;
    logic run;
    logic tick_lo;
    logic tick_hi;
    logic hof_set;
    logic lof_set;
    logic cap_set;
    timer_pkg::mode_t mode;

    assign cnt16 = {cnt_hi_ff, cnt_lo_ff};
    assign rld16 = {rld_hi_ff, rld_lo_ff};

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_clksel = clksel_ff;
        nxt_irqen = irqen_ff;
        nxt_cnt_lo = cnt_lo_ff;
        nxt_cnt_hi = cnt_hi_ff;
        nxt_rld_lo = rld_lo_ff;
        nxt_rld_hi = rld_hi_ff;
        nxt_status = status_ff;
        nxt_mask = mask_ff;
        hof_set = 1'b0;
        lof_set = 1'b0;
        cap_set = 1'b0;
        run = ctrl_ff[`CTRL_RUN];
        if (ctrl_ff[`CTRL_SPLIT]) begin
            mode = timer_pkg::MODE_SPLIT;
        end else if (ctrl_ff[`CTRL_CEN]) begin
            mode = timer_pkg::MODE_CAPTURE;
        end else begin
            mode = timer_pkg::MODE_WIDE;
        end
        // Capture never runs from the external divider
        tick_lo = clksel_ff[`CLK_LO_BIT] ? 1'b1 :
            ((ctrl_ff[`CTRL_XCLK] && mode != timer_pkg::MODE_CAPTURE)
            ? ext_tick : tick12);
        tick_hi = clksel_ff[`CLK_HI_BIT] ? 1'b1 :
            (ctrl_ff[`CTRL_XCLK] ? ext_tick : tick12);
        unique case (mode)
            timer_pkg::MODE_SPLIT: begin
                // Low half ignores run while split
                if (tick_lo) begin
                    if (cnt_lo_ff == 8'hFF) begin
                        nxt_cnt_lo = rld_lo_ff;
                        lof_set = 1'b1;
                    end else begin
                        nxt_cnt_lo = cnt_lo_ff + 8'h01;
                    end
                end
                if (run && tick_hi) begin
                    if (cnt_hi_ff == 8'hFF) begin
                        nxt_cnt_hi = rld_hi_ff;
                        hof_set = 1'b1;
                    end else begin
                        nxt_cnt_hi = cnt_hi_ff + 8'h01;
                    end
                end
            end
            timer_pkg::MODE_WIDE, timer_pkg::MODE_CAPTURE: begin
                if (run && tick_lo) begin
                    if (cnt16 == 16'hFFFF) begin
                        nxt_cnt_hi = rld_hi_ff;
                        nxt_cnt_lo = rld_lo_ff;
                        hof_set = 1'b1;
                        lof_set = 1'b1;
                    end else begin
                        {nxt_cnt_hi, nxt_cnt_lo} = cnt16 + 16'h0001;
                        lof_set = (cnt_lo_ff == 8'hFF);
                    end
                end
                if (mode == timer_pkg::MODE_CAPTURE && cmp_rise) begin
                    nxt_rld_hi = cnt_hi_ff;
                    nxt_rld_lo = cnt_lo_ff;
                    hof_set = 1'b1;
                    cap_set = 1'b1;
                end
            end
        endcase
        // A write in the same cycle overrides the counter and reload updates
        if (reg_wr) begin
            unique case (reg_addr)
                `ADDR_CTRL: nxt_ctrl = reg_wdata & `CTRL_WMASK;
                `ADDR_CLKSEL: nxt_clksel = reg_wdata[1:0];
                `ADDR_IRQEN: nxt_irqen = reg_wdata[`IRQEN_BIT];
                `ADDR_CNT_LO: nxt_cnt_lo = reg_wdata;
                `ADDR_CNT_HI: nxt_cnt_hi = reg_wdata;
                `ADDR_RLD_LO: nxt_rld_lo = reg_wdata;
                `ADDR_RLD_HI: nxt_rld_hi = reg_wdata;
                `ADDR_STATUS: nxt_status = status_ff & ~reg_wdata[2:0];
                `ADDR_MASK: nxt_mask = reg_wdata[2:0];
                default: ;
            endcase
        end
        // Hardware sets win over a clearing write; no self clear
        nxt_ctrl[`CTRL_HOF] = nxt_ctrl[`CTRL_HOF] | hof_set;
        nxt_ctrl[`CTRL_LOF] = nxt_ctrl[`CTRL_LOF] | lof_set;
        nxt_status = nxt_status | {cap_set, lof_set, hof_set};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_ff <= `CTRL_RST;
            clksel_ff <= `CLKSEL_RST;
            irqen_ff <= 1'b0;
            cnt_lo_ff <= `BYTE_RST;
            cnt_hi_ff <= `BYTE_RST;
            rld_lo_ff <= `BYTE_RST;
            rld_hi_ff <= `BYTE_RST;
            status_ff <= `EV_RST;
            mask_ff <= `EV_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            clksel_ff <= nxt_clksel;
            irqen_ff <= nxt_irqen;
            cnt_lo_ff <= nxt_cnt_lo;
            cnt_hi_ff <= nxt_cnt_hi;
            rld_lo_ff <= nxt_rld_lo;
            rld_hi_ff <= nxt_rld_hi;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
        end
    end

    // -----------------------------------------------------------
    // Read data and interrupt output
    // -----------------------------------------------------------
    logic [7:0] nxt_rdata;
    logic nxt_irq;

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_CTRL: nxt_rdata = ctrl_ff;
                `ADDR_CLKSEL: nxt_rdata = {6'h00, clksel_ff};
                `ADDR_IRQEN: nxt_rdata = {7'h00, irqen_ff};
                `ADDR_CNT_LO: nxt_rdata = cnt_lo_ff;
                `ADDR_CNT_HI: nxt_rdata = cnt_hi_ff;
                `ADDR_RLD_LO: nxt_rdata = rld_lo_ff;
                `ADDR_RLD_HI: nxt_rdata = rld_hi_ff;
                `ADDR_STATUS: nxt_rdata = {5'h00, status_ff};
                `ADDR_MASK: nxt_rdata = {5'h00, mask_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
        // Control low flag only requests when its own enable is set; status bits request through the mask
        nxt_irq = (irqen_ff & (ctrl_ff[`CTRL_HOF] |
            (ctrl_ff[`CTRL_LIE] & ctrl_ff[`CTRL_LOF]))) |
            (|(status_ff & mask_ff));
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            reg_rdata <= nxt_rdata;
            irq <= nxt_irq;
        end
    end

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    a_wide_reload: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        mode == timer_pkg::MODE_WIDE && run && tick_lo &&
        cnt16 == 16'hFFFF && !reg_wr
        |=> cnt16 == $past(rld16) && ctrl_ff[`CTRL_HOF])
        else $error("wide wrap did not reload");

    a_div12_period: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        tick12 |=> (!tick12) [*8] ##1 !tick12 ##1 !tick12
        ##1 !tick12 ##1 tick12)
        else $error("divide by twelve tick period wrong");

    a_split_low_free: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        mode == timer_pkg::MODE_SPLIT && tick_lo &&
        cnt_lo_ff != 8'hFF && !reg_wr
        |=> cnt_lo_ff == 8'($past(cnt_lo_ff) + 8'h01))
        else $error("split low half did not count");

    a_split_high_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        mode == timer_pkg::MODE_SPLIT && !run && !reg_wr
        |=> $stable(cnt_hi_ff))
        else $error("stopped high half moved");

    a_split_low_flag: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        mode == timer_pkg::MODE_SPLIT && tick_lo &&
        cnt_lo_ff == 8'hFF && !reg_wr
        |=> ctrl_ff[`CTRL_LOF] && cnt_lo_ff == $past(rld_lo_ff))
        else $error("split low wrap missed flag or reload");

    a_flag_sticky: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ctrl_ff[`CTRL_HOF] && !reg_wr |=> ctrl_ff[`CTRL_HOF])
        else $error("high flag cleared by hardware");

    a_capture_copy: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        mode == timer_pkg::MODE_CAPTURE && cmp_rise && !reg_wr
        |=> rld16 == $past(cnt16) && ctrl_ff[`CTRL_HOF]
        && status_ff[`EV_CAP])
        else $error("capture did not copy count");

    a_irq_high: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        irqen_ff && ctrl_ff[`CTRL_HOF] |=> irq)
        else $error("high overflow gave no interrupt");

    a_irq_low: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        irqen_ff && ctrl_ff[`CTRL_LIE] && ctrl_ff[`CTRL_LOF] |=> irq)
        else $error("low overflow gave no interrupt");

endmodule // reload_timer_with_capture

//--- logic/timer_defs.svh
// Register map, field positions, reset values and divider counts
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_CLKSEL 4'h1
`define ADDR_IRQEN 4'h2
`define ADDR_CNT_LO 4'h3
`define ADDR_CNT_HI 4'h4
`define ADDR_RLD_LO 4'h5
`define ADDR_RLD_HI 4'h6
`define ADDR_STATUS 4'h7
`define ADDR_MASK 4'h8

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_HOF 7
`define CTRL_LOF 6
`define CTRL_LIE 5
`define CTRL_CEN 4
`define CTRL_SPLIT 3
`define CTRL_RUN 2
`define CTRL_XCLK 0
`define CTRL_WMASK 8'hFD
`define CLK_LO_BIT 0
`define CLK_HI_BIT 1
`define IRQEN_BIT 0
`define EV_HOF 0
`define EV_LOF 1
`define EV_CAP 2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CTRL_RST 8'h00
`define CLKSEL_RST 2'h0
`define BYTE_RST 8'h00
`define EV_RST 3'h0

// ---------------------------------------------------------------
// Divider counts
// ---------------------------------------------------------------
`define DIV12_LAST 4'hB
`define EXT_DIV_LAST 3'h7

`endif

//--- logic/timer_pkg.sv
// Types shared by the reload timer
package timer_pkg;

    typedef enum logic [1:0] {
        MODE_WIDE = 2'b00,
        MODE_SPLIT = 2'b01,
        MODE_CAPTURE = 2'b10
    } mode_t;

endpackage

//--- verif/osc_cmp_model.sv
// Stand-in for the comparator output and the external oscillator
`timescale 1ns/1ps
module osc_cmp_model (
    input logic sys_clk,
    output logic ext_osc,
    output logic cmp_out
);
    initial begin
        ext_osc = 1'b0;
        cmp_out = 1'b0;
    end

    // Oscillator stands low between bursts; three clocks high, three low
    task automatic osc_burst(input int n);
        repeat (n) begin
            repeat (3) @(posedge sys_clk);
            ext_osc <= 1'b1;
            repeat (3) @(posedge sys_clk);
            ext_osc <= 1'b0;
        end
    endtask

    // Two rises gap clocks apart, each held far longer than a tick
    task automatic cmp_two(input int gap);
        repeat (2) begin
            @(posedge sys_clk);
            cmp_out <= 1'b1;
            repeat (40) @(posedge sys_clk);
            cmp_out <= 1'b0;
            repeat (gap - 41) @(posedge sys_clk);
        end
    endtask
endmodule // osc_cmp_model

//--- verif/reload_timer_with_capture_tb.sv
// Self-checking bench for the reload timer
`timescale 1ns/1ps
`include "timer_defs.svh"
module reload_timer_with_capture_tb;
    logic sys_clk;
    logic sys_rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic ext_osc;
    logic cmp_out;
    logic irq;
    logic [7:0] rd_val;
    logic [15:0] cap_a;
    logic [15:0] cap_b;
    logic [15:0] cap_diff;
    int num_errors;
    int samples_checked;
    int cycles;

    reload_timer_with_capture i_dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .ext_osc(ext_osc),
        .cmp_out(cmp_out),
        .irq(irq)
    );

    osc_cmp_model i_model (
        .sys_clk(sys_clk),
        .ext_osc(ext_osc),
        .cmp_out(cmp_out)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ---------------------------------------------------------------
    // Bus and check tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Ends off the edge so registered outputs are read where they stand
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rd_val = reg_rdata;
    endtask

    // Read strobe follows the write with no gap
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rd_val = reg_rdata;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        // Address 9 is unmapped and must read zero
        for (int a = 0; a < 10; a++) begin
            rd(4'(a));
            chk(rd_val, 8'h00);
        end
        $display("test reset done");
    endtask

    task automatic t_wide();
        wr(`ADDR_CLKSEL, 8'h01);
        wr(`ADDR_RLD_LO, 8'h34);
        wr(`ADDR_RLD_HI, 8'h12);
        wr(`ADDR_CNT_HI, 8'hFF);
        wr(`ADDR_MASK, 8'h01);
        wr(`ADDR_CTRL, 8'h04);
        wr_rd(`ADDR_CNT_LO, 8'hF0);
        chk(rd_val, 8'hF0);
        cyc(30);
        rd(`ADDR_CNT_HI);
        chk(rd_val, 8'h12);
        rd(`ADDR_CTRL);
        chk(rd_val, 8'hC4);
        rd(`ADDR_STATUS);
        chk(rd_val, 8'h03);
        chk({7'h0, irq}, 8'h01);
        wr(`ADDR_CTRL, 8'hC0);
        wr(`ADDR_STATUS, 8'h03);
        cyc(2);
        chk({7'h0, irq}, 8'h00);
        wr(`ADDR_IRQEN, 8'h01);
        cyc(2);
        chk({7'h0, irq}, 8'h01);
        cyc(50);
        rd(`ADDR_CTRL);
        chk(rd_val, 8'hC0);
        wr(`ADDR_MASK, 8'h00);
        wr(`ADDR_CNT_HI, 8'h00);
        wr(`ADDR_CNT_LO, 8'hFE);
        wr(`ADDR_CTRL, 8'h24);
        cyc(20);
        rd(`ADDR_CTRL);
        chk(rd_val, 8'h64);
        chk({7'h0, irq}, 8'h01);
        wr(`ADDR_CTRL, 8'h00);
        cyc(2);
        chk({7'h0, irq}, 8'h00);
        $display("test wide done");
    endtask

    task automatic t_split();
        wr(`ADDR_RLD_LO, 8'hF0);
        wr(`ADDR_CNT_HI, 8'h05);
        wr(`ADDR_CNT_LO, 8'hFE);
        wr(`ADDR_CTRL, 8'h08);
        cyc(40);
        rd(`ADDR_CNT_HI);
        chk(rd_val, 8'h05);
        rd(`ADDR_CNT_LO);
        chk({4'h0, rd_val[7:4]}, 8'h0F);
        rd(`ADDR_CTRL);
        chk(rd_val, 8'h48);
        chk({7'h0, irq}, 8'h00);
        wr(`ADDR_CTRL, 8'h68);
        cyc(2);
        chk({7'h0, irq}, 8'h01);
        wr(`ADDR_CTRL, 8'h0D);
        wr(`ADDR_CNT_HI, 8'h00);
        i_model.osc_burst(16);
        cyc(6);
        rd(`ADDR_CNT_HI);
        chk(rd_val, 8'h02);
        wr(`ADDR_CTRL, 8'h0C);
        wr(`ADDR_CNT_HI, 8'h00);
        cyc(120);
        rd(`ADDR_CNT_HI);
        chk({7'h0, rd_val >= 8'h0A && rd_val <= 8'h0B}, 8'h01);
        wr(`ADDR_CLKSEL, 8'h03);
        wr(`ADDR_RLD_HI, 8'hA0);
        wr(`ADDR_CNT_HI, 8'hFE);
        cyc(4);
        rd(`ADDR_CTRL);
        chk(rd_val & 8'hBF, 8'h8C);
        chk({7'h0, irq}, 8'h01);
        rd(`ADDR_CNT_HI);
        chk({4'h0, rd_val[7:4]}, 8'h0A);
        $display("test split done");
    endtask

    // The first capture is read back before the second overwrites it
    task automatic cap_pair(input int gap);
        fork
            i_model.cmp_two(gap);
            begin
                cyc(20);
                rd(`ADDR_RLD_LO);
                cap_a[7:0] = rd_val;
                rd(`ADDR_RLD_HI);
                cap_a[15:8] = rd_val;
            end
        join
        cyc(20);
        rd(`ADDR_RLD_LO);
        cap_b[7:0] = rd_val;
        rd(`ADDR_RLD_HI);
        cap_b[15:8] = rd_val;
        cap_diff = cap_b - cap_a;
    endtask

    task automatic t_capture();
        wr(`ADDR_CLKSEL, 8'h01);
        wr(`ADDR_STATUS, 8'h07);
        wr(`ADDR_CTRL, 8'h14);
        // Rises are 100 clocks apart and the counter ticks every clock
        cap_pair(100);
        chk(cap_diff[7:0], 8'h64);
        chk(cap_diff[15:8], 8'h00);
        rd(`ADDR_CTRL);
        chk(rd_val & 8'hBF, 8'h94);
        chk({7'h0, irq}, 8'h01);
        rd(`ADDR_STATUS);
        chk(rd_val & 8'h05, 8'h05);
        // External select must fall back to the divide-by-12 tick
        wr(`ADDR_CLKSEL, 8'h00);
        wr(`ADDR_CTRL, 8'h15);
        cap_pair(120);
        chk(cap_diff[7:0], 8'h0A);
        chk(cap_diff[15:8], 8'h00);
        wr(`ADDR_CTRL, 8'h1C);
        i_model.cmp_two(100);
        rd(`ADDR_RLD_LO);
        chk(rd_val, cap_b[7:0]);
        $display("test capture done");
    endtask

    // ---------------------------------------------------------------
    // Run control
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        num_errors = 0;
        samples_checked = 0;
        sys_rst <= 1'b1;
        reg_addr <= 4'h0;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        cyc(5);
        sys_rst <= 1'b0;
        t_reset();
        t_wide();
        t_split();
        t_capture();
        test_done();
    end
endmodule // reload_timer_with_capture_tb
